// ===== bench/line_far_end.sv
// far-end transceiver model: resolves both line wires and tallies bits per frame
`timescale 1ns/1ps
`default_nettype none

module line_far_end
(
  input  wire logic        clk,
  input  wire logic        frameSync,
  input  wire logic        bitStrobe,
  input  wire logic        dataLineOut,
  input  wire logic        dataLineOe,
  input  wire logic        cmdLineOut,
  input  wire logic        cmdLineOe,
  output logic      [31:0] strobes,
  output logic      [31:0] dataOnes,
  output logic      [31:0] cmdOnes
);
  logic [31:0] sCnt = '0;
  logic [31:0] dCnt = '0;
  logic [31:0] cCnt = '0;
  logic        syncPrev = 1'b0;
  logic        dataWire = 1'b0;
  logic        cmdWire = 1'b0;

  always @(posedge clk)
  begin
    // a released wire flips every cycle so a stale level can never pass as data
    dataWire = dataLineOe ? dataLineOut : ~dataWire;
    cmdWire = cmdLineOe ? cmdLineOut : ~cmdWire;
    if (frameSync && !syncPrev)
    begin
      strobes <= sCnt;
      dataOnes <= dCnt;
      cmdOnes <= cCnt;
      sCnt = '0;
      dCnt = '0;
      cCnt = '0;
    end
    else if (bitStrobe)
    begin
      sCnt = sCnt + 32'h1;
      if (dataLineOe && dataWire)
        dCnt = dCnt + 32'h1;
      if (cmdLineOe && cmdWire)
        cCnt = cCnt + 32'h1;
    end
    syncPrev = frameSync;
  end
endmodule : line_far_end

`default_nettype wire

// ===== bench/tdm_line_interface_config_bench.sv
// self-checking bench for the line interface configuration block
`timescale 1ns/1ps
`default_nettype none
`include "tdm_line_cfg.svh"

module tdm_line_interface_config_bench
  import tdm_line_pkg::*;
;
  logic        clk, rst, psel, penable, pwrite, frameSync, txBit, cmdBit, err;
  logic        pready, pslverr, bitStrobe, dataLineOut, dataLineOe, cmdLineOut, cmdLineOe;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, strobes, dataOnes, cmdOnes, rd;
  logic [4:0]  slotChannel;
  logic [15:0] modeWord [3];
  logic [3:0]  cfgSeq [4] = '{4'h4, 4'hd, 4'he, 4'hf};
  int          bad_count, tests_run, k, seedVal, nCh;

  tdm_line_interface_config dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frameSync(frameSync), .txBit(txBit), .cmdBit(cmdBit),
    .bitStrobe(bitStrobe), .slotChannel(slotChannel), .dataLineOut(dataLineOut),
    .dataLineOe(dataLineOe), .cmdLineOut(cmdLineOut), .cmdLineOe(cmdLineOe));

  line_far_end farEnd (.clk(clk), .frameSync(frameSync), .bitStrobe(bitStrobe),
    .dataLineOut(dataLineOut), .dataLineOe(dataLineOe), .cmdLineOut(cmdLineOut),
    .cmdLineOe(cmdLineOe), .strobes(strobes), .dataOnes(dataOnes), .cmdOnes(cmdOnes));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic int expChans(input logic [1:0] r);
    return (r == 2'b00) ? 8 : (r == 2'b01) ? 16 : (r == 2'b10) ? 24 : 0;
  endfunction : expChans

  // bits per frame for a rate code; onlyOn keeps the channels not switched off
  function automatic logic [31:0] expBits(input logic [1:0] r, input logic onlyOn);
    int n, b, c;
    n = expChans(r);
    b = (r == 2'b10) ? int'(`RATE2_SLOT_BITS) :
        (r == 2'b01) ? int'(`RATE1_SLOT_BITS) : int'(`RATE0_SLOT_BITS);
    c = 0;
    for (int i = 0; i < n; i++)
      if (!onlyOn || modeWord[i / 8][2 * (i % 8) +: 2] != MODE_OFF)
        c++;
    return 32'(c * b);
  endfunction : expBits

  initial
  begin
    repeat (80000) @(posedge clk);
    bad_count++;
    summarize();
  end

  initial
  begin
    {psel, penable, pwrite, frameSync} = 4'h0;
    paddr = 16'h0;
    pwdata = 32'h0;
    txBit = 1'b1;
    cmdBit = 1'b1;
    rst = 1'b1;
    bad_count = 0;
    tests_run = 0;
    seedVal = $urandom(32'hb108);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `CFG_OFFSET, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 16'hd0b0, 32'h0);
    chk({rd[31:1], err}, 32'h1);
    for (k = 0; k < 3; k++)
    begin
      apb(1'b0, `MODE0_OFFSET + 16'(4 * k), 32'h0);
      chk(rd, 32'hffff);
      modeWord[k] = 16'($urandom);
      apb(1'b1, `MODE0_OFFSET + 16'(4 * k), {16'($urandom), modeWord[k]});
      apb(1'b0, `MODE0_OFFSET + 16'(4 * k), 32'h0);
      chk(rd, {16'h0, modeWord[k]});
    end
    for (k = 1; k <= 5; k++)
    begin
      // new rate lands after the last bit of the frame and before the next sync
      if (k < 5)
        apb(1'b1, `CFG_OFFSET, {28'($urandom), cfgSeq[k - 1]});
      if (k == 1)
        chk(32'(dataLineOe), 32'h0);
      @(posedge clk);
      frameSync <= 1'b1;
      repeat (20) @(posedge clk);
      frameSync <= 1'b0;
      if (k > 1)
      begin
        chk(strobes, expBits(cfgSeq[k - 2][1:0], 1'b0));
        chk(dataOnes, expBits(cfgSeq[k - 2][1:0], 1'b1));
        chk(cmdOnes, (k == 4) ? expBits(2'b10, 1'b0) : 32'h0);
      end
      if (k < 5)
      begin
        apb(1'b0, `CFG_OFFSET, 32'h0);
        chk(rd, {27'h0, 1'(k % 2), cfgSeq[k - 1]});
        repeat (12540) @(posedge clk);
        // engine parks on the last channel, or stays on channel 0 at the reserved rate
        nCh = expChans(cfgSeq[k - 1][1:0]);
        chk(32'(slotChannel), (nCh == 0) ? 32'h0 : 32'(nCh - 1));
      end
    end
    apb(1'b1, `CFG_OFFSET, 32'h0);
    repeat (2) @(posedge clk);
    chk({30'h0, dataLineOe, cmdLineOe}, 32'h0);
    summarize();
  end
endmodule : tdm_line_interface_config_bench

`default_nettype wire

// ===== rtl/channel_mode_bank.sv
// per-channel mode registers: three words of eight two-bit mode fields
`timescale 1ns/1ps
`default_nettype none
`include "tdm_line_cfg.svh"

module channel_mode_bank
  import tdm_line_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        writeEn,
  input  wire logic [1:0]  writeIdx,
  input  wire logic [15:0] writeData,
  input  wire logic [1:0]  readIdx,
  output logic      [15:0] readData,
  input  wire logic [4:0]  slotChannel,
  output mode_type         slotMode
);

  logic [15:0] mode_q [3];
  logic [15:0] mode_d [3];

  function automatic mode_type modeOf(input logic [15:0] word, input logic [2:0] idx);
    modeOf = mode_type'(word[{idx, 1'b0} +: 2]);
  endfunction : modeOf

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_word
      always_comb
      begin
        mode_d[g] = mode_q[g];
        if (writeEn && writeIdx == 2'(g))
          mode_d[g] = writeData;
      end

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          mode_q[g] <= `MODE_RESET;
        else
          mode_q[g] <= mode_d[g];
      end

      property p_mode_write;
        @(posedge clk) disable iff (rst)
        (writeEn && writeIdx == 2'(g)) |=> mode_q[g] == $past(writeData);
      endproperty
      a_mode_write: assert property (p_mode_write) else $error("mode word not written");
    end
  endgenerate

  assign readData = (readIdx < 2'd3) ? mode_q[readIdx] : 16'h0000;
  assign slotMode = (slotChannel[4:3] < 2'd3) ? modeOf(mode_q[slotChannel[4:3]], slotChannel[2:0])
                                              : MODE_OFF;

endmodule : channel_mode_bank
`default_nettype wire

// ===== rtl/tdm_line_cfg.svh
// register map, field positions, reset values and timing counts of the line interface
`ifndef TDM_LINE_CFG_SVH
`define TDM_LINE_CFG_SVH

`define CFG_OFFSET      16'hd0a0
`define MODE0_OFFSET    16'hd0a4
`define MODE1_OFFSET    16'hd0a8
`define MODE2_OFFSET    16'hd0ac

`define CFG_RESET       16'h0000
`define MODE_RESET      16'hffff

`define RATE_LSB        0
`define RATE_MSB        1
`define DATA_EN_BIT     2
`define CMD_EN_BIT      3
`define PHASE_BIT       4

`define CLK_KHZ         64'd100000
`define RATE0_KBPS      64'd3072
`define RATE1_KBPS      64'd6144
`define RATE2_KBPS      64'd12288
`define ACC_SCALE       64'd16777216
`define HALF_FRAME_US   250

`define RATE0_CHANNELS  5'd8
`define RATE1_CHANNELS  5'd16
`define RATE2_CHANNELS  5'd24
`define RATE0_SLOT_BITS 7'd48
`define RATE1_SLOT_BITS 7'd48
`define RATE2_SLOT_BITS 7'd64

`endif

// ===== rtl/tdm_line_interface_config.sv
// line interface global configuration, frame phase tracking and downstream slot engine
// Function
// - rate code picks bit rate and channels
// - data line tri-stated unless enabled, from 4 kHz frame
// - command line tri-stated unless enabled, from 4 kHz frame
// - phase bit read-only, toggles every 250 us
// - phase bit 1 in first half
// - unused configuration bits read zero
// - configuration reads zero after reset
// - each channel mode individually settable
// - mode codes; disabled channel sends zeros on the data line, command bits still sent
`timescale 1ns/1ps
`default_nettype none
`include "tdm_line_cfg.svh"

module tdm_line_interface_config
  import tdm_line_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        frameSync,
  input  wire logic        txBit,
  input  wire logic        cmdBit,
  output logic             bitStrobe,
  output logic      [4:0]  slotChannel,
  output logic             dataLineOut,
  output logic             dataLineOe,
  output logic             cmdLineOut,
  output logic             cmdLineOe
);

  localparam logic [23:0] INC0 = 24'((`RATE0_KBPS * `ACC_SCALE) / `CLK_KHZ);
  localparam logic [23:0] INC1 = 24'((`RATE1_KBPS * `ACC_SCALE) / `CLK_KHZ);
  localparam logic [23:0] INC2 = 24'((`RATE2_KBPS * `ACC_SCALE) / `CLK_KHZ);

  function automatic logic [2:0] decode(input logic [15:0] addr);
    case (addr)
      `CFG_OFFSET:   decode = 3'b100;
      `MODE0_OFFSET: decode = 3'b000;
      `MODE1_OFFSET: decode = 3'b001;
      `MODE2_OFFSET: decode = 3'b010;
      default:       decode = 3'b011;
    endcase
  endfunction : decode

  // apb slave
  logic [2:0]  selDec;
  logic        hit;
  logic        setup;
  logic        wrAccess;
  logic [15:0] modeRead;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  assign selDec   = decode(paddr);
  assign hit      = selDec != 3'b011;
  assign setup    = psel && !penable;
  assign wrAccess = psel && penable && pwrite && hit;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !hit;
  assign prdata   = prdata_q;

  // configuration register
  rate_type rate_q;
  rate_type rate_d;
  logic     dataEnReq_q;
  logic     dataEnReq_d;
  logic     cmdEnReq_q;
  logic     cmdEnReq_d;
  logic     phase_q;

  always_comb
  begin
    rate_d      = rate_q;
    dataEnReq_d = dataEnReq_q;
    cmdEnReq_d  = cmdEnReq_q;
    if (wrAccess && selDec == 3'b100)
    begin
      // phase bit is not writable
      rate_d      = rate_type'(pwdata[`RATE_MSB:`RATE_LSB]);
      dataEnReq_d = pwdata[`DATA_EN_BIT];
      cmdEnReq_d  = pwdata[`CMD_EN_BIT];
    end
  end

  always_comb
  begin
    prdata_d = prdata_q;
    if (setup)
    begin
      prdata_d = 32'h0000_0000;
      if (selDec == 3'b100)
      begin
        prdata_d[`RATE_MSB:`RATE_LSB] = rate_q;
        prdata_d[`DATA_EN_BIT]        = dataEnReq_q;
        prdata_d[`CMD_EN_BIT]         = cmdEnReq_q;
        prdata_d[`PHASE_BIT]          = phase_q;
      end
      else if (hit)
        prdata_d[15:0] = modeRead;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rate_q      <= RATE_3M;
      dataEnReq_q <= 1'b0;
      cmdEnReq_q  <= 1'b0;
      prdata_q    <= 32'h0000_0000;
    end
    else
    begin
      rate_q      <= rate_d;
      dataEnReq_q <= dataEnReq_d;
      cmdEnReq_q  <= cmdEnReq_d;
      prdata_q    <= prdata_d;
    end
  end

  // frame sync from the pin, then phase and line enables
  logic fsMeta_q;
  logic fsSync_q;
  logic fsPrev_q;
  logic frameStart;
  logic quarterStart;
  logic phase_d;
  logic dataEn_q;
  logic dataEn_d;
  logic command_line_enable_q;
  logic command_line_enable_d;

  assign frameStart   = fsSync_q && !fsPrev_q;
  assign quarterStart = frameStart && !phase_q;

  always_comb
  begin
    phase_d  = frameStart ? !phase_q : phase_q;
    // switching off waits for no frame boundary; the line stops driving one cycle after the enable bit clears
    dataEn_d = dataEnReq_q && (dataEn_q || quarterStart);
    command_line_enable_d  = cmdEnReq_q && (command_line_enable_q || quarterStart);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fsMeta_q <= 1'b0;
      fsSync_q <= 1'b0;
      fsPrev_q <= 1'b0;
      phase_q  <= 1'b0;
      dataEn_q <= 1'b0;
      command_line_enable_q  <= 1'b0;
    end
    else
    begin
      fsMeta_q <= frameSync;
      fsSync_q <= fsMeta_q;
      fsPrev_q <= fsSync_q;
      phase_q  <= phase_d;
      dataEn_q <= dataEn_d;
      command_line_enable_q  <= command_line_enable_d;
    end
  end

  assign dataLineOe = dataEn_q;
  assign cmdLineOe  = command_line_enable_q;

  // slot engine: fractional divider makes the bit-rate enable
  logic [23:0] inc;
  logic [4:0]  numChannels;
  logic [6:0]  slotBits;
  logic [23:0] acc_q;
  logic [23:0] acc_d;
  logic [5:0]  bitCnt_q;
  logic [5:0]  bitCnt_d;
  logic [4:0]  chan_q;
  logic [4:0]  chan_d;
  logic        active_q;
  logic        active_d;
  logic        bitTick;
  logic        strobe_q;
  logic        dataOut_q;
  logic        dataOut_d;
  logic        cmdOut_q;
  logic        cmdOut_d;
  mode_type    slotMode;

  always_comb
  begin
    case (rate_q)
      RATE_3M:
      begin
        inc = INC0; numChannels = `RATE0_CHANNELS; slotBits = `RATE0_SLOT_BITS;
      end
      RATE_6M:
      begin
        inc = INC1; numChannels = `RATE1_CHANNELS; slotBits = `RATE1_SLOT_BITS;
      end
      RATE_12M:
      begin
        inc = INC2; numChannels = `RATE2_CHANNELS; slotBits = `RATE2_SLOT_BITS;
      end
      default:
      begin
        inc = 24'h000000; numChannels = 5'h00; slotBits = 7'h00;
      end
    endcase
  end

  always_comb
  begin
    logic [24:0] sum;
    sum       = {1'b0, acc_q} + {1'b0, inc};
    bitTick   = sum[24] && active_q && rate_q != RATE_RSVD;
    acc_d     = sum[23:0];
    bitCnt_d  = bitCnt_q;
    chan_d    = chan_q;
    active_d  = active_q;
    dataOut_d = dataOut_q;
    cmdOut_d  = cmdOut_q;
    if (bitTick)
    begin
      dataOut_d = (slotMode == MODE_OFF) ? 1'b0 : txBit;
      cmdOut_d  = cmdBit;
      // slot length of 64 needs a seventh bit in the compare
      if ({1'b0, bitCnt_q} == slotBits - 7'd1)
      begin
        bitCnt_d = 6'h00;
        if (chan_q == numChannels - 5'd1)
          active_d = 1'b0;
        else
          chan_d = chan_q + 5'd1;
      end
      else
        bitCnt_d = bitCnt_q + 6'd1;
    end
    if (frameStart)
    begin
      acc_d    = 24'h000000;
      bitCnt_d = 6'h00;
      chan_d   = 5'h00;
      active_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      acc_q     <= 24'h000000;
      bitCnt_q  <= 6'h00;
      chan_q    <= 5'h00;
      active_q  <= 1'b0;
      strobe_q  <= 1'b0;
      dataOut_q <= 1'b0;
      cmdOut_q  <= 1'b0;
    end
    else
    begin
      acc_q     <= acc_d;
      bitCnt_q  <= bitCnt_d;
      chan_q    <= chan_d;
      active_q  <= active_d;
      strobe_q  <= bitTick;
      dataOut_q <= dataOut_d;
      cmdOut_q  <= cmdOut_d;
    end
  end

  assign bitStrobe   = strobe_q;
  assign slotChannel = chan_q;
  assign dataLineOut = dataOut_q;
  assign cmdLineOut  = cmdOut_q;

  channel_mode_bank u_modes
  (
    .clk         (clk),
    .rst         (rst),
    .writeEn     (wrAccess && !selDec[2]),
    .writeIdx    (selDec[1:0]),
    .writeData   (pwdata[15:0]),
    .readIdx     (selDec[1:0]),
    .readData    (modeRead),
    .slotChannel (chan_q),
    .slotMode    (slotMode)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_rsvd_idle;
    rate_q == RATE_RSVD |=> !bitStrobe;
  endproperty
  a_rsvd_idle: assert property (p_rsvd_idle) else $error("bit enable on reserved rate");

  property p_data_off;
    !dataEnReq_q |=> !dataLineOe;
  endproperty
  a_data_off: assert property (p_data_off) else $error("data line driven while disabled");

  property p_data_on_edge;
    $rose(dataLineOe) |-> $past(quarterStart);
  endproperty
  a_data_on_edge: assert property (p_data_on_edge) else $error("data line on off boundary");

  property p_cmd_on_edge;
    $rose(cmdLineOe) |-> $past(quarterStart) && $past(cmdEnReq_q);
  endproperty
  a_cmd_on_edge: assert property (p_cmd_on_edge) else $error("command line on off boundary");

  property p_phase_steady;
    !frameStart |=> phase_q == $past(phase_q);
  endproperty
  a_phase_steady: assert property (p_phase_steady) else $error("phase changed without frame");

  property p_phase_read;
    setup && selDec == 3'b100 |=> prdata_q[`PHASE_BIT] == $past(phase_q);
  endproperty
  a_phase_read: assert property (p_phase_read) else $error("phase bit read wrong");

  property p_unused_zero;
    setup && selDec == 3'b100 |=> prdata_q[31:5] == 27'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits not zero");

  property p_reset_value;
    $past(rst) |-> rate_q == RATE_3M && !dataEnReq_q && !cmdEnReq_q;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("config not zero after reset");

  property p_off_zero;
    bitTick && slotMode == MODE_OFF |=> !dataLineOut;
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("disabled channel sent one");

endmodule : tdm_line_interface_config
`default_nettype wire

// ===== rtl/tdm_line_pkg.sv
// types shared by the line interface configuration logic
package tdm_line_pkg;

  typedef enum logic [1:0]
  {
    RATE_3M   = 2'b00,
    RATE_6M   = 2'b01,
    RATE_12M  = 2'b10,
    RATE_RSVD = 2'b11
  } rate_type;

  typedef enum logic [1:0]
  {
    MODE_LINE_TERM_S = 2'b00,
    MODE_LINE_TERM_T = 2'b01,
    MODE_TWO_WIRE    = 2'b10,
    MODE_OFF         = 2'b11
  } mode_type;

endpackage : tdm_line_pkg
